// File: dpd_cfg.svh
`ifndef DPD_CFG_SVH
`define DPD_CFG_SVH
// bus clock rate and strobe length in bus clocks
`define DPD_CLK_MHZ 100
`define DPD_STROBE_BCLKS 2
`define DPD_STROBE_CYCLES ((`DPD_STROBE_BCLKS < 1) ? 1 : `DPD_STROBE_BCLKS)
// clock-chip decode pattern 111 X XX0b over the 7-bit decode field
`define DPD_DEC_MASK 7'h71
`define DPD_DEC_VALUE 7'h70
// status bus codes
`define DPD_W8 2'h0
`define DPD_W16 2'h1
`define DPD_W32 2'h2
`define DPD_WIDLE 2'h3
`define DPD_T_COMPAT 2'h0
`define DPD_T_BURST 2'h3
`define DPD_ST_IDLE 4'hF
// interrupt-8 position in the request vector
`define DPD_IRQ8_BIT 8
`define DPD_CHANNELS 7
`endif

// File: dpd_pkg.sv
package dpd_pkg;
  typedef enum logic [0:0] {DPD_IDLE, DPD_SERVE} dpd_state_type;
endpackage

// File: dpd_strobe.sv
`timescale 1ns/1ns
`include "dpd_cfg.svh"
module dpd_strobe import dpd_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_fall,
  input wire logic [6:0] decode_field,
  output logic clock_chip_addr_strobe
);
  logic first_seen_q;
  logic [1:0] cnt_q;
  logic match;

  assign match = (decode_field & `DPD_DEC_MASK) == `DPD_DEC_VALUE;

  // =====================================================
  // strobe timing
  // held high from reset until the first command strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      first_seen_q <= 1'b0;
    end else if (cmd_fall) begin
      first_seen_q <= 1'b1;
    end
  end

  // a new command restarts the pulse rather than extending it
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 2'h0;
    end else if (cmd_fall && match) begin
      cnt_q <= 2'(`DPD_STROBE_CYCLES);
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      clock_chip_addr_strobe <= 1'b1;
    end else begin
      clock_chip_addr_strobe <= ~(first_seen_q | cmd_fall)
        | (cmd_fall && match) | (cnt_q > 2'h1);
    end
  end

  // =====================================================
  // checks
  // commands come at least three cycles apart, so the pulse must end by itself
  sequence s_pulse_body;
    clock_chip_addr_strobe [*2] ##1 !clock_chip_addr_strobe;
  endsequence
  property p_pulse_end;
    @(posedge clk) disable iff (reset) first_seen_q && cmd_fall && match |=> s_pulse_body;
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("strobe pulse not two bus clocks");
  property p_pulse_len;
    @(posedge clk) disable iff (reset)
      first_seen_q && cmd_fall && match |=> clock_chip_addr_strobe ##1 clock_chip_addr_strobe;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("strobe shorter than two bus clocks");
  property p_no_match;
    @(posedge clk) disable iff (reset)
      first_seen_q && cmd_fall && !match && cnt_q == 2'h0 |=> !clock_chip_addr_strobe;
  endproperty
  a_no_match: assert property (p_no_match)
    else $error("strobe without decode match");
  property p_reset_hold;
    @(posedge clk) disable iff (reset) !first_seen_q && !$past(reset) |-> clock_chip_addr_strobe;
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("strobe dropped before first command");
endmodule

// File: dpd_top.sv
`timescale 1ns/1ns
`include "dpd_cfg.svh"
// Notes on behaviour
// - otherwise select pin is active-low irq8
// - float test pin in reset; pull-up external
// - flag addresses above 16M during DMA
// - drive refresh low for own refresh
// - foreign refresh steers status and ready direction
// - pulse terminate line at terminal count
// - terminate input stops current transfer
// - address enable while DMA drives address
// - two-clock strobe on matching command
// - strobe high from reset to first command
// - upper status bits carry requester width
// - lower status bits carry cycle timing
module dpd_top import dpd_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic clock_irq_or_test_select,
  input wire logic above_boundary_or_test_mode_in,
  output logic above_boundary_or_test_mode_out,
  output logic above_boundary_or_test_mode_oe,
  input wire logic [7:0] host_addr_high_bits,
  input wire logic refresh_n_in,
  output logic refresh_n_out,
  output logic refresh_n_oe,
  input wire logic own_refresh,
  input wire logic dma_terminate_line_in,
  output logic dma_terminate_line_out,
  output logic dma_terminate_line_oe,
  input wire logic [6:0] dma_req,
  input wire logic dma_grant,
  input wire logic xfer_done,
  input wire logic [15:0] word_count,
  input wire logic [13:0] chan_width,
  input wire logic [13:0] chan_timing,
  output logic [6:0] dma_ack,
  output logic address_enable_n,
  output logic [3:0] interchip_status_bus_out,
  output logic interchip_status_bus_oe,
  input wire logic dma_ready_line_in,
  output logic dma_ready_line_out,
  output logic dma_ready_line_oe,
  input wire logic cmd_n,
  input wire logic [6:0] decode_field,
  output logic clock_chip_addr_strobe,
  input wire logic [15:0] irq_lines,
  input wire logic [15:0] irq_enable,
  output logic host_interrupt,
  output logic test_mode,
  output logic dma_ready_seen
);
  // =====================================================
  // pin synchronisers
  localparam int SW = 21;
  logic [SW-1:0] pin_raw, sync1_q, sync2_q;
  logic tsel_s, tmod_s, refresh_s, term_s, cmd_s, cmd_prev_q, ready_s;
  logic [15:0] irq_s;

  assign pin_raw = {clock_irq_or_test_select, above_boundary_or_test_mode_in, refresh_n_in,
                    dma_terminate_line_in, cmd_n, irq_lines};

  // no reset here: the test straps must still be seen at reset release
  always_ff @(posedge clk) begin
    sync1_q <= pin_raw;
    sync2_q <= sync1_q;
  end
  assign {tsel_s, tmod_s, refresh_s, term_s, cmd_s, irq_s} = sync2_q;

  // ready line sampled on its own pair, read only as a status copy
  logic ready1_q, ready2_q;
  always_ff @(posedge clk) begin
    ready1_q <= dma_ready_line_in;
    ready2_q <= ready1_q;
  end
  assign ready_s = ready2_q;
  assign dma_ready_seen = ready_s;

  // =====================================================
  // test mode capture at trailing edge of reset
  logic reset_q, test_mode_q;
  always_ff @(posedge clk) begin
    reset_q <= reset;
    if (reset) begin
      test_mode_q <= 1'b0;
    end else if (reset_q) begin
      test_mode_q <= tsel_s & ~tmod_s;
    end
  end
  assign test_mode = test_mode_q;

  // =====================================================
  // dma channel service
  dpd_state_type state_q;
  logic [2:0] chan_q;
  logic [15:0] count_q;
  logic tc_q;
  logic [2:0] pick;
  logic any_req, serving, foreign_refresh;

  // lowest numbered request wins; fixed priority keeps it simple
  always_comb begin
    pick = 3'h0;
    for (int i = `DPD_CHANNELS - 1; i >= 0; i--) begin
      if (dma_req[i]) begin
        pick = 3'(i);
      end
    end
  end
  assign any_req = |dma_req;
  assign serving = (state_q == DPD_SERVE) && !test_mode_q;

  // our own pulses come back through the pin synchronisers two cycles late;
  // masking them keeps them from reading as a slave stop or an isa refresh
  logic [1:0] tc_echo_q, own_rf_echo_q;
  logic slave_stop_s;
  always_ff @(posedge clk) begin
    if (reset) begin
      tc_echo_q <= 2'h0;
      own_rf_echo_q <= 2'h0;
    end else begin
      tc_echo_q <= {tc_echo_q[0], tc_q};
      own_rf_echo_q <= {own_rf_echo_q[0], own_refresh};
    end
  end
  assign slave_stop_s = term_s && !(|tc_echo_q);

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= DPD_IDLE;
      chan_q <= 3'h0;
      count_q <= 16'h0000;
    end else begin
      unique case (state_q)
        DPD_IDLE: begin
          if (dma_grant && any_req && !test_mode_q && !slave_stop_s) begin
            state_q <= DPD_SERVE;
            chan_q <= pick;
            count_q <= word_count;
          end
        end
        DPD_SERVE: begin
          if (slave_stop_s || !dma_grant || !dma_req[chan_q]) begin
            state_q <= DPD_IDLE;
          end else if (xfer_done) begin
            if (count_q == 16'h0000) begin
              state_q <= DPD_IDLE;
            end
            count_q <= count_q - 16'h0001;
          end
        end
      endcase
    end
  end

  // terminal count pulse, one cycle, on the last transfer
  always_ff @(posedge clk) begin
    if (reset) begin
      tc_q <= 1'b0;
    end else begin
      tc_q <= serving && !slave_stop_s && dma_grant && dma_req[chan_q] && xfer_done
              && count_q == 16'h0000;
    end
  end
  assign dma_terminate_line_out = 1'b1;
  assign dma_terminate_line_oe = tc_q && !test_mode_q;

  // acknowledge outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      dma_ack <= 7'h00;
    end else begin
      for (int i = 0; i < `DPD_CHANNELS; i++) begin
        dma_ack[i] <= (state_q == DPD_SERVE) && chan_q == 3'(i) && !test_mode_q;
      end
    end
  end

  // address enable and above-16M flag, active low
  assign address_enable_n = ~serving;
  assign above_boundary_or_test_mode_out = ~(serving && host_addr_high_bits != 8'h00);
  assign above_boundary_or_test_mode_oe = !reset && !test_mode_q;

  // =====================================================
  // refresh and status direction
  assign refresh_n_out = 1'b0;
  assign refresh_n_oe = own_refresh && !test_mode_q && !reset;
  // low refresh line while we are not driving it means an isa master refresh
  assign foreign_refresh = !refresh_s && !own_refresh && !(|own_rf_echo_q);

  // status code; burst is demoted for 8-bit requesters
  function automatic logic [3:0] status_code(input logic [1:0] w, input logic [1:0] t);
    logic [1:0] tt;
    tt = (t == `DPD_T_BURST && w == `DPD_W8) ? `DPD_T_COMPAT : t;
    status_code = {w, tt};
  endfunction

  always_ff @(posedge clk) begin
    if (reset) begin
      interchip_status_bus_out <= `DPD_ST_IDLE;
    end else if (state_q == DPD_SERVE) begin
      interchip_status_bus_out <= status_code(chan_width[2*chan_q +: 2], chan_timing[2*chan_q +: 2]);
    end else begin
      interchip_status_bus_out <= `DPD_ST_IDLE;
    end
  end
  assign interchip_status_bus_oe = (serving || own_refresh) && !foreign_refresh && !test_mode_q;
  assign dma_ready_line_out = 1'b1;
  assign dma_ready_line_oe = foreign_refresh && !test_mode_q;

  // =====================================================
  // clock-chip strobe and host interrupt
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_prev_q <= 1'b1;
    end else begin
      cmd_prev_q <= cmd_s;
    end
  end

  dpd_strobe u_strobe (
    .clk(clk),
    .reset(reset),
    .cmd_fall(cmd_prev_q && !cmd_s),
    .decode_field(decode_field),
    .clock_chip_addr_strobe(clock_chip_addr_strobe)
  );

  logic [15:0] irq_active;
  // irq8 is the select pin itself, active low; bit 8 of irq_lines is not used
  assign irq_active = {irq_s[15:9], ~tsel_s, irq_s[7:0]};
  always_ff @(posedge clk) begin
    if (reset) begin
      host_interrupt <= 1'b0;
    end else begin
      host_interrupt <= |(irq_active & irq_enable) && !test_mode_q;
    end
  end

  // =====================================================
  // checks
  property p_test_entry;
    @(posedge clk) reset_q && !reset && tsel_s && !tmod_s |=> test_mode;
  endproperty
  a_test_entry: assert property (p_test_entry)
    else $error("test mode not entered");
  property p_float;
    @(posedge clk) reset |-> !above_boundary_or_test_mode_oe;
  endproperty
  a_float: assert property (p_float)
    else $error("test pin driven in reset");
  sequence s_above;
    serving && host_addr_high_bits != 8'h00;
  endsequence
  property p_above;
    @(posedge clk) disable iff (reset) s_above |-> !above_boundary_or_test_mode_out;
  endproperty
  a_above: assert property (p_above)
    else $error("above-16M not flagged");
  property p_term_stop;
    @(posedge clk) disable iff (reset) serving && slave_stop_s |=> state_q == DPD_IDLE ##1 dma_ack == 7'h00;
  endproperty
  a_term_stop: assert property (p_term_stop)
    else $error("transfer not stopped by terminate");
  property p_ack;
    @(posedge clk) disable iff (reset) $rose(serving) |=> $onehot(dma_ack) && dma_ack[chan_q];
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge missing");
  property p_status;
    @(posedge clk) disable iff (reset) interchip_status_bus_out[1:0] == `DPD_T_BURST
      |-> interchip_status_bus_out[3:2] != `DPD_W8;
  endproperty
  a_status: assert property (p_status)
    else $error("burst on 8-bit requester");
  property p_irq;
    @(posedge clk) disable iff (reset) |(irq_active & irq_enable) && !test_mode_q |=> host_interrupt;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised");
endmodule

// File: dpd_bus_partner.sv
`timescale 1ns/1ns
// ==========
// expansion slots and companion controller
module dpd_bus_partner (
  input wire logic foreign_refresh,
  input wire logic slave_stop,
  input wire logic strap_low,
  input wire logic hold_ready,
  input wire logic refresh_n_oe,
  input wire logic refresh_n_out,
  input wire logic term_oe,
  input wire logic term_out,
  input wire logic ready_oe,
  input wire logic ready_out,
  input wire logic test_oe,
  input wire logic test_out,
  output logic refresh_pin,
  output logic term_pin,
  output logic ready_pin,
  output logic test_pin
);
  // wired-low refresh on a pulled-up line, isa master may pull too
  assign refresh_pin = !((refresh_n_oe && !refresh_n_out) || foreign_refresh);
  // slave_stop reaches the line whenever the device is not driving it
  assign term_pin = term_oe ? term_out : slave_stop;
  // companion holds ready low on hold_ready and high otherwise, unless the device owns it
  assign ready_pin = ready_oe ? ready_out : !hold_ready;
  // pull-up keeps the pin high, a tester strap pulls it low
  assign test_pin = test_oe ? test_out : !strap_low;
endmodule

// File: dpd_top_tb_top.sv
`timescale 1ns/1ns
module dpd_top_tb_top;
  // ==========
  // stimulus and pins
  logic clk = 0, reset = 1, sel = 1, own_rf = 0, grant = 0, xd = 0, cmd_n = 1;
  logic frf = 0, stop = 0, strap = 0, hold_rdy = 0;
  logic [7:0] haddr = 8'h00;
  logic [6:0] req = 7'h00, dec = 7'h00, ack;
  logic [15:0] wc = 16'h0000, irq = 16'h0100, irq_en = 16'h0000;
  logic [13:0] wid = 14'h0000, tim = 14'h0000;
  logic [3:0] st;
  logic ab_out, ab_oe, rf_out, rf_oe, tc_out, tc_oe, rd_out, rd_oe, aen_n, st_oe, strobe, hint, tmode, rd_seen;
  logic rf_pin, tc_pin, rd_pin, tm_pin;
  int err_count = 0, checks_done = 0, cycles = 0, tc_seen = 0;

  dpd_top u_dut (.clk(clk), .reset(reset), .clock_irq_or_test_select(sel),
    .above_boundary_or_test_mode_in(tm_pin), .above_boundary_or_test_mode_out(ab_out),
    .above_boundary_or_test_mode_oe(ab_oe), .host_addr_high_bits(haddr), .refresh_n_in(rf_pin),
    .refresh_n_out(rf_out), .refresh_n_oe(rf_oe), .own_refresh(own_rf), .dma_terminate_line_in(tc_pin),
    .dma_terminate_line_out(tc_out), .dma_terminate_line_oe(tc_oe), .dma_req(req), .dma_grant(grant),
    .xfer_done(xd), .word_count(wc), .chan_width(wid), .chan_timing(tim), .dma_ack(ack),
    .address_enable_n(aen_n), .interchip_status_bus_out(st), .interchip_status_bus_oe(st_oe),
    .dma_ready_line_in(rd_pin), .dma_ready_line_out(rd_out), .dma_ready_line_oe(rd_oe), .cmd_n(cmd_n),
    .decode_field(dec), .clock_chip_addr_strobe(strobe), .irq_lines(irq), .irq_enable(irq_en),
    .host_interrupt(hint), .test_mode(tmode), .dma_ready_seen(rd_seen));

  dpd_bus_partner u_bus (.foreign_refresh(frf), .slave_stop(stop), .strap_low(strap), .hold_ready(hold_rdy),
    .refresh_n_oe(rf_oe), .refresh_n_out(rf_out), .term_oe(tc_oe), .term_out(tc_out), .ready_oe(rd_oe),
    .ready_out(rd_out), .test_oe(ab_oe), .test_out(ab_out), .refresh_pin(rf_pin), .term_pin(tc_pin),
    .ready_pin(rd_pin), .test_pin(tm_pin));

  // clock, hang guard well above the expected run, terminal count pulses
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    tc_seen <= tc_seen + int'(tc_oe && tc_out);
    if (cycles == 3000) begin
      err_count++;
      test_done();
    end
  end

  // ==========
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // strap held past release so it clears the synchroniser
  task automatic do_reset(input logic low);
    @(posedge clk);
    reset <= 1'b1;
    strap <= low;
    step(2);
    chk({strobe, ab_oe, tm_pin, st}, {2'b10, !low, 4'hF}, "reset state");
    @(posedge clk) reset <= 1'b0;
    step(3);
    @(posedge clk) strap <= 1'b0;
    step(2);
    chk(tmode, low, "test mode entry");
  endtask

  // ==========
  // scenarios
  task automatic t_strobe();
    int n = 0;
    chk(strobe, 1'b1, "strobe before first command");
    @(posedge clk) cmd_n <= 1'b0;
    dec <= 7'h71;
    step(8);
    chk(strobe, 1'b0, "strobe after miss");
    @(posedge clk) cmd_n <= 1'b1;
    step(4);
    @(posedge clk) cmd_n <= 1'b0;
    dec <= 7'h7E;
    repeat (10) begin
      step(1);
      n += int'(strobe);
    end
    chk(n, 2, "strobe length");
    @(posedge clk) cmd_n <= 1'b1;
    step(4);
    $display("test strobe done");
  endtask
  task automatic t_dma();
    int t0 = tc_seen;
    @(posedge clk) haddr <= 8'h01;
    wc <= 16'h0001;
    wid <= 14'h0010;
    tim <= 14'h0010;
    req <= 7'h04;
    grant <= 1'b1;
    step(1);
    repeat (10) if (ack === 7'h00) step(1);
    chk(ack, 7'h04, "ack channel");
    chk({aen_n, ab_oe, ab_out}, 3'b010, "address flags");
    chk(st, 4'h5, "status width timing");
    repeat (2) begin
      @(posedge clk) xd <= 1'b1;
      @(posedge clk) xd <= 1'b0;
    end
    step(3);
    chk(tc_seen - t0, 1, "terminal pulse");
    @(posedge clk) req <= 7'h00;
    grant <= 1'b0;
    step(1);
    repeat (10) if (ack !== 7'h00) step(1);
    chk({ack, st}, 11'h00F, "service over");
    $display("test dma done");
  endtask
  task automatic t_stop();
    @(posedge clk) wc <= 16'h00FF;
    wid <= 14'h0000;
    tim <= 14'h0003;
    req <= 7'h01;
    grant <= 1'b1;
    step(1);
    repeat (10) if (ack === 7'h00) step(1);
    chk({ack, st}, 11'h010, "8-bit burst demoted");
    @(posedge clk) stop <= 1'b1;
    step(1);
    repeat (8) if (ack !== 7'h00) step(1);
    chk(ack, 7'h00, "slave stop");
    @(posedge clk) stop <= 1'b0;
    req <= 7'h00;
    grant <= 1'b0;
    step(8);
    $display("test stop done");
  endtask
  task automatic t_refresh();
    @(posedge clk) hold_rdy <= 1'b1;
    step(3);
    chk(rd_seen, 1'b0, "ready held low");
    @(posedge clk) own_rf <= 1'b1;
    hold_rdy <= 1'b0;
    step(1);
    chk({rf_oe, rf_pin, st_oe}, 3'b101, "own refresh");
    @(posedge clk) own_rf <= 1'b0;
    frf <= 1'b1;
    step(4);
    chk({rd_oe, st_oe, rf_oe, rd_seen}, 4'h9, "foreign refresh");
    @(posedge clk) frf <= 1'b0;
    step(4);
    chk(rd_oe, 1'b0, "ready released");
    $display("test refresh done");
  endtask
  task automatic t_irq();
    @(posedge clk) irq_en <= 16'h0108;
    irq <= 16'h0108;
    step(5);
    chk(hint, 1'b1, "irq pending");
    @(posedge clk) irq_en <= 16'h0100;
    step(5);
    chk(hint, 1'b0, "irq masked");
    @(posedge clk) irq <= 16'h0100;
    sel <= 1'b0;
    step(5);
    chk(hint, 1'b1, "irq8 active low");
    @(posedge clk) irq <= 16'h0100;
    sel <= 1'b1;
    irq_en <= 16'h0000;
    step(5);
    chk(hint, 1'b0, "irq cleared");
    $display("test irq done");
  endtask
  task automatic t_test();
    do_reset(1'b1);
    @(posedge clk) req <= 7'h01;
    grant <= 1'b1;
    own_rf <= 1'b1;
    step(6);
    chk({ack, ab_oe, rf_oe, st_oe}, 10'h000, "test mode quiet");
    @(posedge clk) req <= 7'h00;
    grant <= 1'b0;
    own_rf <= 1'b0;
    do_reset(1'b0);
    $display("test mode done");
  endtask

  // ==========
  // main sequence
  initial begin
    do_reset(1'b0);
    t_strobe();
    t_dma();
    t_stop();
    t_refresh();
    t_irq();
    t_test();
    test_done();
  end
endmodule
